// ===== hdl/sfc_defines.svh
/*
  Constants of the fan controller serial port: address, direction and
  acknowledge encodings, command codes and bus timing.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

`define SFC_SLAVE_ADDR      7'h1b
`define SFC_DIR_READ        1'b1
`define SFC_DIR_WRITE       1'b0
`define SFC_ACK             1'b0
`define SFC_NACK            1'b1
`define SFC_CMD_FAN_FAULT   8'h02
`define SFC_CMD_CONFIG      8'h04
`define SFC_CFG_SHUTDOWN    0
`define SFC_SHUTDOWN_RESET  1'b0
`define SFC_ACK_BIT         4'h8
`define SFC_CLOCK_NS        25
`define SFC_QUARTER_NS      2500
`define SFC_QUARTER_CYC     (`SFC_QUARTER_NS / `SFC_CLOCK_NS)

`endif

// ===== hdl/sfc_link_if.sv
/*
  Two-wire link between the bus master and the fan controller slave.
  Assumes pull-ups: a line is low only while some party drives it low.
*/
`timescale 1ns/1ps
interface sfc_link_if;
  logic m_scl_oe;
  logic m_scl_o;
  logic m_sda_oe;
  logic m_sda_o;
  logic s_sda_oe;
  logic s_sda_o;
  logic scl;
  logic sda;

  // wired-and with pull-up; scl from the master only, sda from both parties
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (
    output m_scl_oe,
    output m_scl_o,
    output m_sda_oe,
    output m_sda_o,
    input  scl,
    input  sda
  );

  modport slave (
    output s_sda_oe,
    output s_sda_o,
    input  scl,
    input  sda
  );
endinterface

// ===== hdl/sfc_master.sv
/*
  Master end of the fan controller serial port. Runs a write byte,
  read byte or receive byte transfer per command and makes the bus
  clock by dividing i_clock into quarter bit periods.
  Assumes it is the only master on the link.
*/
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_master (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  sfc_link_if.master             link,
  input  wire logic              i_cmd_valid,
  input  wire sfc_pkg::sfc_kind_t i_cmd_kind,
  input  wire logic [7:0]        i_cmd_code,
  input  wire logic [7:0]        i_cmd_data,
  output logic                   o_cmd_ready,
  output logic                   o_done,
  output logic                   o_nack,
  output logic [7:0]             o_rd_data
);
  import sfc_pkg::*;

  localparam logic [6:0] QLAST = 7'(`SFC_QUARTER_CYC - 1);

  sfc_mst_state_t st_q;
  sfc_kind_t      kind_q;
  logic [6:0]     div_q;
  logic [1:0]     ph_q;
  logic [3:0]     bit_q;
  logic [1:0]     step_q;
  logic [7:0]     code_q, data_q, sh_q;
  logic           scl_low_q, oe_q, sda_s1_q, sda_s2_q;

  logic tick_w, rx_w, last_w, rstart_w, ack_w, take_w;
  logic [7:0] tx_w;

  // per-step byte plan of the three protocols
  // first address byte always carries write or receive
  assign rx_w     = (kind_q == SFC_READ_BYTE && step_q == 2'h3) ||
                    (kind_q == SFC_RECV_BYTE && step_q == 2'h1);
  assign last_w   = rx_w || (kind_q == SFC_WRITE_BYTE && step_q == 2'h2);
  assign rstart_w = (kind_q == SFC_READ_BYTE && step_q == 2'h1);
  assign tx_w     = (step_q == 2'h1) ? code_q :
                    (step_q == 2'h2 && kind_q == SFC_WRITE_BYTE) ? data_q :
                    (step_q == 2'h2 || kind_q == SFC_RECV_BYTE) ?
                    {`SFC_SLAVE_ADDR, `SFC_DIR_READ} :
                    {`SFC_SLAVE_ADDR, `SFC_DIR_WRITE};
  assign tick_w   = (div_q == QLAST);
  assign ack_w    = (bit_q == `SFC_ACK_BIT);
  // start only on an idle bus
  assign take_w   = o_cmd_ready & i_cmd_valid & sda_s2_q & ~scl_low_q;

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = scl_low_q;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = oe_q;

  always_ff @(posedge i_clock)
  begin
    sda_s1_q <= link.sda;
    sda_s2_q <= sda_s1_q;
  end

  // quarter-period sequencer: p0 set data, p1 rise, p2 sample, p3 fall
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      st_q        <= SFC_M_IDLE;
      kind_q      <= SFC_WRITE_BYTE;
      div_q       <= 7'h00;
      ph_q        <= 2'h0;
      bit_q       <= 4'h0;
      step_q      <= 2'h0;
      code_q      <= 8'h00;
      data_q      <= 8'h00;
      sh_q        <= 8'h00;
      scl_low_q   <= 1'b0;
      oe_q        <= 1'b0;
      o_cmd_ready <= 1'b1;
      o_done      <= 1'b0;
      o_nack      <= 1'b0;
      o_rd_data   <= 8'h00;
    end
    else
    begin
      o_done <= 1'b0;
      div_q  <= (tick_w || st_q == SFC_M_IDLE) ? 7'h00 : div_q + 7'h01;
      if (tick_w)
        ph_q <= ph_q + 2'h1;
      unique case (st_q)
        SFC_M_IDLE:
        begin
          ph_q <= 2'h0;
          if (take_w)
          begin
            kind_q      <= i_cmd_kind;
            code_q      <= i_cmd_code;
            data_q      <= i_cmd_data;
            step_q      <= 2'h0;
            o_nack      <= 1'b0;
            o_cmd_ready <= 1'b0;
            st_q        <= SFC_M_START;
          end
        end
        SFC_M_START:
        begin
          // sda falls during scl high
          // scl released a quarter early, so a repeated start never
          // moves both lines in one cycle
          if (tick_w)
          begin
            oe_q      <= (ph_q >= 2'h1);
            scl_low_q <= (ph_q == 2'h3);
            bit_q     <= 4'h0;
            if (ph_q == 2'h3)
              st_q <= SFC_M_BIT;
          end
        end
        SFC_M_BIT:
        begin
          if (tick_w)
            unique case (ph_q)
              2'h0:
              begin
                // msb first; ack bit left released
                // nack on the only read byte
                if (bit_q == 4'h0)
                  sh_q <= tx_w;
                oe_q <= !rx_w && !ack_w &&
                        ((bit_q == 4'h0) ? ~tx_w[7] : ~sh_q[7]);
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2:
              begin
                if (!ack_w)
                  sh_q <= {sh_q[6:0], rx_w ? sda_s2_q : 1'b0};
                // high during ack clock is nack
                else if (!rx_w && sda_s2_q == `SFC_NACK)
                  o_nack <= 1'b1;
              end
              2'h3:
              begin
                scl_low_q <= 1'b1;
                bit_q     <= ack_w ? 4'h0 : bit_q + 4'h1;
                if (ack_w)
                begin
                  if (rx_w)
                    o_rd_data <= sh_q;
                  step_q <= step_q + 2'h1;
                  if (last_w || o_nack)
                    st_q <= SFC_M_STOP;
                  else if (rstart_w)
                    st_q <= SFC_M_START;
                end
              end
            endcase
        end
        SFC_M_STOP:
        begin
          // sda rises during scl high
          // sda held low through the scl rise, released a quarter later
          if (tick_w)
          begin
            oe_q <= (ph_q <= 2'h1);
            if (ph_q == 2'h1)
              scl_low_q <= 1'b0;
            if (ph_q == 2'h3)
            begin
              st_q        <= SFC_M_IDLE;
              o_done      <= 1'b1;
              o_cmd_ready <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule // sfc_master

// ===== hdl/sfc_pkg.sv
/*
  Types of the fan controller serial port: transfer kinds and the
  states of both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfc_pkg;
  typedef enum logic [1:0] {
    SFC_WRITE_BYTE,
    SFC_READ_BYTE,
    SFC_RECV_BYTE
  } sfc_kind_t;

  typedef enum logic [2:0] {
    SFC_S_IDLE,
    SFC_S_RX,
    SFC_S_RX_ACK,
    SFC_S_TX,
    SFC_S_TX_ACK
  } sfc_slv_state_t;

  typedef enum logic [1:0] {
    SFC_M_IDLE,
    SFC_M_START,
    SFC_M_BIT,
    SFC_M_STOP
  } sfc_mst_state_t;
endpackage

// ===== hdl/sfc_slave.sv
/*
  Slave end of the fan controller serial port. Bus logic runs on the
  link clock and oversamples both lines; register traffic is handed to
  the user side on i_clock through toggle handshakes.
  Assumes a link clock far faster than the bus clock (>= 16 link cycles
  per bus clock half period) and a user that answers a read request
  with i_rd_data in the same cycle as o_rd_req.
*/
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_slave (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_link_clock,
  sfc_link_if.slave       link,
  output logic            o_wr_valid,
  output logic [7:0]      o_wr_cmd,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_req,
  output logic [7:0]      o_rd_cmd,
  input  wire logic [7:0] i_rd_data,
  output logic            o_shutdown_request_bit
);
  import sfc_pkg::*;

  // link domain state
  logic           lrst_s1_q, lrst_q;
  logic           scl_s1_q, scl_s2_q, scl_p_q;
  logic           sda_s1_q, sda_s2_q, sda_p_q;
  logic           rak_s1_q, rak_s2_q, rak_p_q;
  sfc_slv_state_t st_q, st_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [1:0]     idx_q, idx_d;
  logic [7:0]     sh_q, sh_d;
  logic [7:0]     cmd_q, cmd_d;
  logic [7:0]     wdat_q, wdat_d;
  logic [7:0]     rd_q;
  logic           dir_q, dir_d;
  logic           wtg_q, wtg_d;
  logic           rtg_q, rtg_d;
  logic           oe_q, oe_d;
  // user domain state
  logic           w_s1_q, w_s2_q, w_p_q;
  logic           r_s1_q, r_s2_q, r_p_q;
  logic           rak_tg_q;
  logic [7:0]     rd_hold_q;

  logic start_w, stop_w, rise_w, fall_w, addr_hit_w, rak_ev_w;
  logic wr_ev_w, rd_ev_w, cfg_wr_w;

  // line events on synchronised samples
  // start detection
  assign start_w    = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_w     = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign rise_w     = scl_s2_q & ~scl_p_q;
  assign fall_w     = ~scl_s2_q & scl_p_q;
  assign addr_hit_w = (sh_q[7:1] == `SFC_SLAVE_ADDR);
  assign rak_ev_w   = rak_s2_q ^ rak_p_q;

  // clock never driven; sda only pulled low
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = oe_q;

  // bit engine; line changes happen only on scl falling
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    idx_d  = idx_q;
    sh_d   = sh_q;
    cmd_d  = cmd_q;
    wdat_d = wdat_q;
    dir_d  = dir_q;
    wtg_d  = wtg_q;
    rtg_d  = rtg_q;
    oe_d   = oe_q;
    // start and stop override any state
    if (start_w)
    begin
      st_d  = SFC_S_RX;
      cnt_d = 4'h0;
      idx_d = 2'h0;
      oe_d  = 1'b0;
    end
    else if (stop_w)
    begin
      st_d = SFC_S_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        SFC_S_IDLE:
        begin
          oe_d = 1'b0;
        end
        SFC_S_RX:
        begin
          if (rise_w)
          begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end
          else if (fall_w && cnt_q == `SFC_ACK_BIT)
          begin
            cnt_d = 4'h0;
            if (idx_q == 2'h0 && !addr_hit_w)
              st_d = SFC_S_IDLE;
            else
            begin
              // pull low for the ack pulse
              oe_d = 1'b1;
              st_d = SFC_S_RX_ACK;
              if (idx_q == 2'h0)
              begin
                dir_d = sh_q[0];
                if (sh_q[0] == `SFC_DIR_READ)
                  rtg_d = ~rtg_q;
              end
              else if (idx_q == 2'h1)
                cmd_d = sh_q;
              else
              begin
                wdat_d = sh_q;
                wtg_d  = ~wtg_q;
              end
              if (idx_q != 2'h2)
                idx_d = idx_q + 2'h1;
            end
          end
        end
        SFC_S_RX_ACK:
        begin
          // ack pulse ends on this falling edge
          if (fall_w)
          begin
            // repeated start with read bit turns round
            // data of the last selected register
            if (dir_q == `SFC_DIR_READ)
            begin
              st_d = SFC_S_TX;
              sh_d = rd_q;
              oe_d = ~rd_q[7];
            end
            else
            begin
              st_d = SFC_S_RX;
              oe_d = 1'b0;
            end
          end
        end
        SFC_S_TX:
        begin
          if (rise_w)
            cnt_d = cnt_q + 4'h1;
          // new bit only while scl low
          else if (fall_w)
          begin
            if (cnt_q == `SFC_ACK_BIT)
            begin
              oe_d  = 1'b0;
              cnt_d = 4'h0;
              st_d  = SFC_S_TX_ACK;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        SFC_S_TX_ACK:
        begin
          // nack ends sending, sda stays high
          if (rise_w && sda_s2_q == `SFC_NACK)
            st_d = SFC_S_IDLE;
          else if (fall_w)
          begin
            st_d = SFC_S_TX;
            sh_d = rd_q;
            oe_d = ~rd_q[7];
          end
        end
      endcase
    end
  end

  // link reset and pin synchronisers; no reset needed on sync stages
  always_ff @(posedge i_link_clock)
  begin
    lrst_s1_q <= i_reset;
    lrst_q    <= lrst_s1_q;
    scl_s1_q  <= link.scl;
    scl_s2_q  <= scl_s1_q;
    sda_s1_q  <= link.sda;
    sda_s2_q  <= sda_s1_q;
    rak_s1_q  <= rak_tg_q;
    rak_s2_q  <= rak_s1_q;
  end

  // link state; scl and sda history regs start high as on an idle bus
  always_ff @(posedge i_link_clock)
  begin
    if (lrst_q)
    begin
      // idle bus assumed high on both lines
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rak_p_q <= 1'b0;
      st_q    <= SFC_S_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= 2'h0;
      sh_q    <= 8'h00;
      cmd_q   <= 8'h00;
      wdat_q  <= 8'h00;
      rd_q    <= 8'h00;
      dir_q   <= `SFC_DIR_WRITE;
      wtg_q   <= 1'b0;
      rtg_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s2_q;
      sda_p_q <= sda_s2_q;
      rak_p_q <= rak_s2_q;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      sh_q    <= sh_d;
      cmd_q   <= cmd_d;
      wdat_q  <= wdat_d;
      dir_q   <= dir_d;
      wtg_q   <= wtg_d;
      rtg_q   <= rtg_d;
      oe_q    <= oe_d;
      if (rak_ev_w)
        rd_q <= rd_hold_q;
    end
  end

  // user side: toggle edges; cmd_q and wdat_q are quiet when sampled
  assign wr_ev_w  = w_s2_q ^ w_p_q;
  assign rd_ev_w  = r_s2_q ^ r_p_q;
  assign cfg_wr_w = wr_ev_w & (cmd_q == `SFC_CMD_CONFIG);

  always_ff @(posedge i_clock)
  begin
    w_s1_q <= wtg_q;
    w_s2_q <= w_s1_q;
    r_s1_q <= rtg_q;
    r_s2_q <= r_s1_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      w_p_q      <= 1'b0;
      r_p_q      <= 1'b0;
      o_wr_valid <= 1'b0;
      o_wr_cmd   <= 8'h00;
      o_wr_data  <= 8'h00;
      o_rd_req   <= 1'b0;
      o_rd_cmd   <= 8'h00;
      rd_hold_q  <= 8'h00;
      rak_tg_q   <= 1'b0;
      o_shutdown_request_bit <= `SFC_SHUTDOWN_RESET;
    end
    else
    begin
      w_p_q      <= w_s2_q;
      r_p_q      <= r_s2_q;
      o_wr_valid <= wr_ev_w;
      o_rd_req   <= rd_ev_w;
      if (wr_ev_w)
      begin
        o_wr_cmd  <= cmd_q;
        o_wr_data <= wdat_q;
      end
      if (rd_ev_w)
        o_rd_cmd <= cmd_q;
      // answer sampled in the cycle of the request pulse
      if (o_rd_req)
      begin
        rd_hold_q <= i_rd_data;
        rak_tg_q  <= ~rak_tg_q;
      end
      if (cfg_wr_w)
        o_shutdown_request_bit <= wdat_q[`SFC_CFG_SHUTDOWN];
    end
  end
endmodule // sfc_slave

// ===== testbench/sfc_link_properties.sv
/*
  Concurrent checks on the two-wire link joining both ends.
  Assumes a link clock far faster than the bus clock.
*/
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_link_properties (
  input wire logic i_link_clock,
  input wire logic i_reset,
  input wire logic m_scl_oe,
  input wire logic m_scl_o,
  input wire logic m_sda_oe,
  input wire logic m_sda_o,
  input wire logic s_sda_oe,
  input wire logic s_sda_o,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic       first_q;
  logic       read_q;
  logic       hit_q;
  logic       busy_q;
  // edge and condition decode of the wires
  wire rise  = scl & ~scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop  = scl & scl_q & ~sda_q & sda;
  wire ack   = rise & (cnt_q == 4'h8);

  default clocking cb @(posedge i_link_clock); endclocking
  default disable iff (i_reset);

  // bit counter restarts on every start, even a repeated one
  always_ff @(posedge i_link_clock)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (i_reset || start)
    begin
      cnt_q   <= 4'h0;
      first_q <= 1'b1;
    end
    else if (ack)
    begin
      cnt_q   <= 4'h0;
      first_q <= 1'b0;
    end
    else if (rise)
    begin
      cnt_q <= cnt_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end

  // direction, address match and busy state of the frame
  always_ff @(posedge i_link_clock)
  begin
    if (ack && first_q)
    begin
      read_q <= sh_q[0];
      hit_q  <= (sh_q[7:1] == `SFC_SLAVE_ADDR);
    end
    busy_q <= !(i_reset || stop) && (busy_q || start);
  end

  AST_ADDR_ACK: assert property (ack && first_q |->
    s_sda_oe == (sh_q[7:1] == `SFC_SLAVE_ADDR)) else $error("addr ack");
  AST_WRITE_ACK: assert property (
    ack && !first_q && !read_q && hit_q |-> s_sda_oe && !sda)
    else $error("write ack missing");
  AST_NACK_RELEASE: assert property (
    ack && !first_q && read_q |-> !s_sda_oe) else $error("no release");
  AST_MASTER_NACK: assert property (
    ack && !first_q && read_q |-> sda && !m_sda_oe)
    else $error("master acked last read byte");
  AST_SLV_HOLD: assert property (scl && scl_q |->
    $stable(s_sda_oe)) else $error("slave moved sda in scl high");
  AST_CLOCK_MASTER: assert property (!scl |-> m_scl_oe)
    else $error("scl low without master");
  AST_HIGH_PULSE: assert property (rise |-> scl [*8])
    else $error("scl pulse too short");
  AST_START_MASTER: assert property (start |->
    m_sda_oe && !s_sda_oe) else $error("start not by master");
  AST_IDLE_QUIET: assert property (!busy_q |->
    scl && !s_sda_oe) else $error("idle bus not high");
  AST_OPEN_DRAIN: assert property (1'b1 |->
    !m_scl_o && !m_sda_o && !s_sda_o) else $error("line driven high");

  // main scenarios reached
  COV_READ_ADDR: cover property (ack && first_q && sh_q[0]);
  COV_READ_NACK: cover property (ack && !first_q && read_q);
  COV_STOP: cover property (stop);
endmodule // sfc_link_properties

// ===== testbench/smbus_fan_ctrl_slave_port_tb_top.sv
/*
  Self-checking bench: master and slave ends joined by the link, a
  register model in arrays and queues predicting every result.
  Assumes the design files and the link checker compiled first.
*/
`timescale 1ns/1ps
`include "sfc_defines.svh"
module smbus_fan_ctrl_slave_port_tb_top;
  import sfc_pkg::*;
  logic        i_clock;
  logic        i_reset;
  logic        i_link_clock;
  logic        cmd_valid;
  sfc_kind_t   cmd_kind;
  logic [7:0]  cmd_code;
  logic [7:0]  cmd_data;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [7:0]  rd_data;
  logic        wr_valid;
  logic [7:0]  wr_cmd;
  logic [7:0]  wr_data;
  logic        rd_req;
  logic [7:0]  rd_cmd;
  logic [7:0]  rd_resp;
  logic        shutdown;
  logic [7:0]  mem [256];
  logic [7:0]  last_cmd;
  logic [15:0] wr_q [$];
  int          num_errors;
  int          cmp_count;
  bit          timed_out;

  sfc_link_if link ();

  sfc_master u_sfc_master (.i_clock(i_clock), .i_reset(i_reset),
    .link(link), .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data),
    .o_cmd_ready(cmd_ready), .o_done(done), .o_nack(nack),
    .o_rd_data(rd_data));

  sfc_slave u_sfc_slave (.i_clock(i_clock), .i_reset(i_reset),
    .i_link_clock(i_link_clock), .link(link), .o_wr_valid(wr_valid),
    .o_wr_cmd(wr_cmd), .o_wr_data(wr_data), .o_rd_req(rd_req),
    .o_rd_cmd(rd_cmd), .i_rd_data(rd_resp),
    .o_shutdown_request_bit(shutdown));

  sfc_link_properties u_sfc_link_properties (
    .i_link_clock(i_link_clock), .i_reset(i_reset),
    .m_scl_oe(link.m_scl_oe), .m_scl_o(link.m_scl_o),
    .m_sda_oe(link.m_sda_oe), .m_sda_o(link.m_sda_o),
    .s_sda_oe(link.s_sda_oe), .s_sda_o(link.s_sda_o),
    .scl(link.scl), .sda(link.sda));

  // user clock and an unrelated link clock
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial
  begin
    i_link_clock = 1'b0;
    #3.7;
    forever #6 i_link_clock = ~i_link_clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // user side of the slave: model answers reads, writes are checked
  always @(negedge i_clock)
  begin
    rd_resp <= mem[rd_cmd];
    if (rd_req)
      chk(16'(rd_cmd), 16'(last_cmd));
    if (wr_valid)
      chk({wr_cmd, wr_data}, wr_q.pop_front());
  end

  // one master transfer; the model predicts before it is issued
  task automatic run(input sfc_kind_t k, input logic [7:0] c, d);
    logic [7:0] exp;
    int         n;
    // after a hang the remaining transfers are skipped
    if (timed_out)
      return;
    exp = 8'h00;
    if (k != SFC_RECV_BYTE)
      last_cmd = c;
    if (k == SFC_WRITE_BYTE)
    begin
      mem[c] = d;
      wr_q.push_back({c, d});
    end
    else
      exp = mem[last_cmd];
    @(negedge i_clock);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_code = c;
    cmd_data = d;
    n = 0;
    while (cmd_ready !== 1'b0 && n < 100)
    begin
      @(negedge i_clock);
      n++;
    end
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 20000)
    begin
      num_errors++;
      timed_out = 1'b1;
    end
    else
    begin
      chk(16'(nack), 16'h0000);
      if (k != SFC_WRITE_BYTE)
        chk(16'(rd_data), 16'(exp));
      chk(16'(shutdown), 16'(mem[`SFC_CMD_CONFIG][0]));
    end
  endtask

  // reset, then writes, reads and a receive against the model
  initial
  begin
    void'($urandom(32'h2949e2ae));
    i_reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = SFC_WRITE_BYTE;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
    last_cmd = 8'h00;
    num_errors = 0;
    cmp_count = 0;
    timed_out = 1'b0;
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (4) @(negedge i_clock);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clock);
    run(SFC_WRITE_BYTE, `SFC_CMD_CONFIG, 8'($urandom) | 8'h01);
    run(SFC_WRITE_BYTE, `SFC_CMD_FAN_FAULT, 8'($urandom));
    run(SFC_READ_BYTE, `SFC_CMD_FAN_FAULT, 8'h00);
    run(SFC_WRITE_BYTE, `SFC_CMD_CONFIG, 8'($urandom) & 8'hfe);
    run(SFC_RECV_BYTE, 8'h00, 8'h00);
    run(SFC_READ_BYTE, 8'h07, 8'h00);
    chk(16'(wr_q.size()), 16'h0000);
    print_verdict();
  end
endmodule // smbus_fan_ctrl_slave_port_tb_top
